// File: ecal_pkg.sv
`default_nettype none
package ecal_pkg;
  localparam int          NPORT          = 3;
  // EEPROM byte offsets of the words walked by the autoload
  localparam logic [7:0]  EE_SIG_OFS     = 8'h00;
  localparam logic [7:0]  EE_VID_OFS     = 8'h02;
  localparam logic [7:0]  EE_DID_OFS     = 8'h04;
  localparam logic [7:0]  EE_MISC0_OFS   = 8'h06;
  localparam logic [7:0]  EE_SSVID_OFS   = 8'h08;
  localparam logic [7:0]  EE_SSID_OFS    = 8'h0A;
  localparam logic [7:0]  EE_MISC1_OFS   = 8'h0C;
  localparam logic [7:0]  EE_LAST_OFS    = 8'h0C;
  localparam logic [7:0]  EE_STEP        = 8'h02;
  localparam logic [15:0] EE_SIGNATURE   = 16'h1516;
  // Source bit positions, misc word 0
  localparam int          M0_EXTVC       = 0;
  localparam int          M0_L0S_LO      = 1;
  localparam int          M0_L1_LO       = 4;
  localparam int          M0_CLKPM       = 7;
  localparam int          M0_NOORD_EGR   = 8;
  localparam int          M0_NOORD_TAG   = 9;
  localparam int          M0_SAF         = 10;
  localparam int          M0_CT_LO       = 11;
  localparam int          M0_ARB         = 13;
  localparam int          M0_CRED        = 14;
  localparam int          M0_NPSAF       = 15;
  // Source bit positions, misc word 1
  localparam int          M1_MPS_LO      = 0;
  localparam int          M1_ASPM_LO     = 2;
  localparam int          M1_RBER        = 4;
  localparam int          M1_MSI_DIS     = 5;
  localparam int          M1_CMP_DIS     = 6;
  localparam int          M1_PM_DIS      = 7;
  localparam int          M1_ORD5        = 8;
  localparam int          M1_LBN         = 9;
  // Destination bit positions in the configuration images
  localparam int          LC_ASPM_LO     = 10;
  localparam int          LC_L0S_LO      = 12;
  localparam int          LC_L1_LO       = 15;
  localparam int          LC_CLKPM       = 18;
  localparam int          LC_LBN         = 21;
  localparam int          DC_MPS_LO      = 0;
  localparam int          DC_RBER        = 15;
  localparam int          CD_PM_DIS      = 13;
  localparam int          CD_MSI_DIS     = 14;
  localparam int          SW_SAF         = 0;
  localparam int          SW_CT_LO       = 1;
  localparam int          SW_ARB         = 3;
  localparam int          SW_CRED        = 4;
  localparam int          SW_NOORD_EGR   = 5;
  localparam int          SW_NOORD_TAG   = 6;
  localparam int          SW_NPSAF       = 7;
  localparam int          SW_CMP_DIS     = 15;
  localparam int          OR_RULE5       = 5;
  localparam int          VC_EXT_CNT     = 0;
  // Reset values, kept when no valid image is found
  localparam logic [15:0] RST_ID         = 16'h0000;
  localparam logic [31:0] RST_LNKCAP     = 32'h0000_0000;
  localparam logic [15:0] RST_DEVCAP     = 16'h0000;
  localparam logic [15:0] RST_CAPDIS     = 16'h0000;
  localparam logic [15:0] RST_SWCTL      = 16'h0000;
  localparam logic [7:0]  RST_ORDER      = 8'h00;
  localparam logic [7:0]  RST_VCCNT      = 8'h00;
endpackage : ecal_pkg
`default_nettype wire

// File: ecal_fetch_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ecal_fetch_if;
  logic        start;
  logic [7:0]  addr;
  logic        done;
  logic [15:0] data;
  modport ctl (output start, output addr, input done, input data);
  modport eng (input start, input addr, output done, output data);
endinterface : ecal_fetch_if
`default_nettype wire

// File: ecal_fetch.sv
`timescale 1ns/1ns
`default_nettype none
module ecal_fetch (
  input  wire logic        sys_clk_i,  // Core clock
  input  wire logic        rst_i,      // Sync reset, high
  ecal_fetch_if.eng        fch,        // Word request from sequencer
  output logic             ee_req_o,   // Word read request, level
  output logic [7:0]       ee_addr_o,  // EEPROM byte offset
  input  wire logic        ee_ack_i,   // Read data valid, pulse
  input  wire logic [15:0] ee_rdata_i  // Read data word
);
  import ecal_pkg::*;

  typedef struct packed {
    logic        req;
    logic [7:0]  addr;
    logic        done;
    logic [15:0] data;
  } ecal_fst_t;

  ecal_fst_t st;
  ecal_fst_t next_st;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (st.req && ee_ack_i) begin
      next_st.req = 1'b0;
      next_st.done = 1'b1;
      next_st.data = ee_rdata_i;
    end else if (!st.req && fch.start) begin
      next_st.req = 1'b1;
      next_st.addr = fch.addr;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ee_req_o  = st.req;
  assign ee_addr_o = st.addr;
  assign fch.done  = st.done;
  assign fch.data  = st.data;

  // (RULE2) ack retires each word
  req_drop_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // (RULE2)
    st.req && ee_ack_i |=> !st.req && st.done)
    else $error("request not retired on ack");
  // (RULE2) offset holds until answered
  addr_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // (RULE2)
    st.req && !ee_ack_i |=> $stable(st.addr) && st.req)
    else $error("address moved during request");
endmodule : ecal_fetch
`default_nettype wire

// File: ecal_top.sv
`timescale 1ns/1ns
`default_nettype none
// Contract
// (RULE1) Autoload starts after reset, only on signature
// (RULE2) Read consecutive words, load their fields
// (RULE3) Host waits for autoload done status
// (RULE4) Word 00h must equal signature value
// (RULE5) Misc0 bit0 to extended VC count
// (RULE6) Misc0 bits 3:1 to L0s latency
// (RULE7) Misc0 bits 6:4 to L1 latency
// (RULE8) Misc0 bit7 to clock PM capability
// (RULE9) Misc0 bit8 to port0 egress no-ordering
// (RULE10) Misc0 bit9 to port0 tag no-ordering
// (RULE11) Misc0 bit10 to port0 store-and-forward
// (RULE12) Misc0 bits 12:11 to cut-through threshold
// (RULE13) Misc0 bit13 to port0 arbiter mode
// (RULE14) Misc0 bit14 to credit update mode
// (RULE15) Misc0 bit15 to non-posted store-forward
// (RULE16) Misc1 bits 1:0 to max payload
// (RULE17) Misc1 bits 3:2 to ASPM support
// (RULE18) Misc1 bit4 to role-based error reporting
// (RULE19) Misc1 bit5 to MSI capability disable
// (RULE20) Misc1 bit6 to compliance parity disable
// (RULE21) Misc1 bit7 to PM capability disable
// (RULE22) Misc1 bit8 to posted-pass ordering rule
// (RULE23) Misc1 bit9 to LBN, ports 1-2
// (RULE24) ID words copied whole into IDs
module ecal_top (
  input  wire logic                          sys_clk_i,     // Core clock
  input  wire logic                          rst_i,         // Sync reset, high
  output logic                               ee_req_o,      // EEPROM word request
  output logic [7:0]                         ee_addr_o,     // EEPROM byte offset
  input  wire logic                          ee_ack_i,      // EEPROM data valid
  input  wire logic [15:0]                   ee_rdata_i,    // EEPROM data word
  output logic                               load_done_o,   // Autoload complete status
  output logic                               sig_ok_o,      // Signature recognised
  output logic [15:0]                        vendor_id_o,   // Vendor ID
  output logic [15:0]                        device_id_o,   // Device ID
  output logic [15:0]                        ss_vendor_o,   // Subsystem vendor ID
  output logic [15:0]                        ss_id_o,       // Subsystem ID
  output logic [ecal_pkg::NPORT-1:0][31:0]   lnk_cap_o,     // Link capability image
  output logic [ecal_pkg::NPORT-1:0][15:0]   dev_cap_o,     // Device capability image
  output logic [ecal_pkg::NPORT-1:0][15:0]   cap_dis_o,     // Capability disable image
  output logic [ecal_pkg::NPORT-1:0][15:0]   sw_ctl_o,      // Switch mode image
  output logic [ecal_pkg::NPORT-1:0][7:0]    order_o,       // Ordering control image
  output logic [ecal_pkg::NPORT-1:0][7:0]    vc_cnt_o       // Extended VC count image
);
  import ecal_pkg::*;

  typedef enum {
    ST_START,
    ST_WAIT,
    ST_DONE
  } ecal_state_t;

  typedef struct packed {
    ecal_state_t                 state;
    logic                        start;
    logic [7:0]                  addr;
    logic                        done;
    logic                        sig_ok;
    logic [15:0]                 vid;
    logic [15:0]                 did;
    logic [15:0]                 ssvid;
    logic [15:0]                 ssid;
    logic [NPORT-1:0][31:0]      lnk_cap;
    logic [NPORT-1:0][15:0]      dev_cap;
    logic [NPORT-1:0][15:0]      cap_dis;
    logic [NPORT-1:0][15:0]      sw_ctl;
    logic [NPORT-1:0][7:0]       order;
    logic [NPORT-1:0][7:0]       vc_cnt;
  } ecal_st_t;

  ecal_st_t st;
  ecal_st_t next_st;

  ecal_fetch_if fch ();

  ecal_fetch u_fetch (
    .sys_clk_i  (sys_clk_i),
    .rst_i      (rst_i),
    .fch        (fch),
    .ee_req_o   (ee_req_o),
    .ee_addr_o  (ee_addr_o),
    .ee_ack_i   (ee_ack_i),
    .ee_rdata_i (ee_rdata_i)
  );

  assign fch.start = st.start;
  assign fch.addr  = st.addr;

  logic [15:0] w;
  assign w = fch.data;

  always_comb begin
    next_st = st;
    next_st.start = 1'b0;
    case (st.state)
      // (RULE1) start right after reset
      ST_START: begin
        next_st.start = 1'b1;
        next_st.addr  = EE_SIG_OFS;
        next_st.state = ST_WAIT;
      end
      ST_WAIT: begin
        if (fch.done) begin
          next_st.state = ST_START;
          case (st.addr)
            EE_SIG_OFS: begin
              // (RULE4) signature gates the load
              next_st.sig_ok = (w == EE_SIGNATURE);
            end
            // (RULE24) identity words copied whole
            EE_VID_OFS:   next_st.vid   = w;
            EE_DID_OFS:   next_st.did   = w;
            EE_SSVID_OFS: next_st.ssvid = w;
            EE_SSID_OFS:  next_st.ssid  = w;
            EE_MISC0_OFS: begin
              for (int p = 0; p < NPORT; p++) begin
                // (RULE5) extended VC count
                next_st.vc_cnt[p][VC_EXT_CNT] = w[M0_EXTVC];
                // (RULE6) L0s exit latency
                next_st.lnk_cap[p][LC_L0S_LO +: 3] = w[M0_L0S_LO +: 3];
                // (RULE7) L1 exit latency
                next_st.lnk_cap[p][LC_L1_LO +: 3] = w[M0_L1_LO +: 3];
                // (RULE8) clock PM capability
                next_st.lnk_cap[p][LC_CLKPM] = w[M0_CLKPM];
              end
              // (RULE9) egress no-ordering, port 0
              next_st.sw_ctl[0][SW_NOORD_EGR] = w[M0_NOORD_EGR];
              // (RULE10) tag no-ordering, port 0
              next_st.sw_ctl[0][SW_NOORD_TAG] = w[M0_NOORD_TAG];
              // (RULE11) store and forward
              next_st.sw_ctl[0][SW_SAF] = w[M0_SAF];
              // (RULE12) cut-through threshold
              next_st.sw_ctl[0][SW_CT_LO +: 2] = w[M0_CT_LO +: 2];
              // (RULE13) arbiter mode
              next_st.sw_ctl[0][SW_ARB] = w[M0_ARB];
              // (RULE14) credit update mode
              next_st.sw_ctl[0][SW_CRED] = w[M0_CRED];
              // (RULE15) non-posted store and forward
              next_st.sw_ctl[0][SW_NPSAF] = w[M0_NPSAF];
            end
            EE_MISC1_OFS: begin
              for (int p = 0; p < NPORT; p++) begin
                // (RULE16) max payload supported
                next_st.dev_cap[p][DC_MPS_LO +: 2] = w[M1_MPS_LO +: 2];
                // (RULE17) ASPM support
                next_st.lnk_cap[p][LC_ASPM_LO +: 2] = w[M1_ASPM_LO +: 2];
                // (RULE18) role-based error reporting
                next_st.dev_cap[p][DC_RBER] = w[M1_RBER];
                // (RULE19) MSI capability disable
                next_st.cap_dis[p][CD_MSI_DIS] = w[M1_MSI_DIS];
                // (RULE20) compliance parity disable
                next_st.sw_ctl[p][SW_CMP_DIS] = w[M1_CMP_DIS];
                // (RULE21) PM capability disable
                next_st.cap_dis[p][CD_PM_DIS] = w[M1_PM_DIS];
                // (RULE22) posted passes non-posted
                next_st.order[p][OR_RULE5] = w[M1_ORD5];
                // (RULE23) LBN on downstream ports only
                if (p != 0) begin
                  next_st.lnk_cap[p][LC_LBN] = w[M1_LBN];
                end
              end
            end
            default: ;
          endcase
          // (RULE2) step to the next word
          if ((st.addr == EE_SIG_OFS && w != EE_SIGNATURE) || st.addr == EE_LAST_OFS) begin
            next_st.state = ST_DONE;
            next_st.done  = 1'b1;
          end else begin
            next_st.start = 1'b1;
            next_st.state = ST_WAIT;
            next_st.addr  = st.addr + EE_STEP;
          end
        end
      end
      ST_DONE: begin
        next_st.state = ST_DONE;
      end
      default: begin
        next_st.state = ST_DONE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st.state  <= ST_START;
      st.start  <= 1'b0;
      st.addr   <= EE_SIG_OFS;
      st.done   <= 1'b0;
      st.sig_ok <= 1'b0;
      st.vid    <= RST_ID;
      st.did    <= RST_ID;
      st.ssvid  <= RST_ID;
      st.ssid   <= RST_ID;
      st.lnk_cap <= {NPORT{RST_LNKCAP}};
      st.dev_cap <= {NPORT{RST_DEVCAP}};
      st.cap_dis <= {NPORT{RST_CAPDIS}};
      st.sw_ctl  <= {NPORT{RST_SWCTL}};
      st.order   <= {NPORT{RST_ORDER}};
      st.vc_cnt  <= {NPORT{RST_VCCNT}};
    end else begin
      st <= next_st;
    end
  end

  // (RULE3) host gates its access on this flag
  assign load_done_o = st.done;
  assign sig_ok_o    = st.sig_ok;
  assign vendor_id_o = st.vid;
  assign device_id_o = st.did;
  assign ss_vendor_o = st.ssvid;
  assign ss_id_o     = st.ssid;

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    assign lnk_cap_o[p] = st.lnk_cap[p];
    assign dev_cap_o[p] = st.dev_cap[p];
    assign cap_dis_o[p] = st.cap_dis[p];
    assign sw_ctl_o[p]  = st.sw_ctl[p];
    assign order_o[p]   = st.order[p];
    assign vc_cnt_o[p]  = st.vc_cnt[p];
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // One-cycle strobes: a word taken in the wait state
  logic        ldw;
  logic        ld0;
  logic        ld1;
  logic        ldv;
  logic        ldd;
  logic        lds;
  logic        ldi;
  assign ldw = (st.state == ST_WAIT) && fch.done;
  assign ld0 = ldw && (st.addr == EE_MISC0_OFS);
  assign ld1 = ldw && (st.addr == EE_MISC1_OFS);
  assign ldv = ldw && (st.addr == EE_VID_OFS);
  assign ldd = ldw && (st.addr == EE_DID_OFS);
  assign lds = ldw && (st.addr == EE_SSVID_OFS);
  assign ldi = ldw && (st.addr == EE_SSID_OFS);

  // (RULE1) first fetch follows reset
  first_fetch_a: assert property ( // (RULE1)
    $fell(rst_i) |-> ##[1:3] (ee_req_o && ee_addr_o == EE_SIG_OFS))
    else $error("autoload did not start after reset");
  // (RULE4) bad signature ends load at once
  bad_sig_a: assert property ( // (RULE4)
    ldw && st.addr == EE_SIG_OFS && w != EE_SIGNATURE
    |=> load_done_o && !sig_ok_o && (st.state == ST_DONE))
    else $error("bad signature not rejected");
  // (RULE4) good signature opens the load
  good_sig_a: assert property ( // (RULE4)
    ldw && st.addr == EE_SIG_OFS && w == EE_SIGNATURE
    |=> sig_ok_o && !load_done_o && st.addr == EE_VID_OFS)
    else $error("good signature not accepted");
  // (RULE1) nothing loads without signature
  no_load_a: assert property (!sig_ok_o && st.addr != EE_SIG_OFS |-> !ee_req_o) // (RULE1)
    else $error("words fetched without signature");
  // (RULE2) offsets advance by one word
  addr_step_a: assert property ( // (RULE2)
    $rose(ee_req_o) && ee_addr_o != EE_SIG_OFS |-> ee_addr_o == $past(st.addr, 2) + EE_STEP)
    else $error("fetch offset not consecutive");
  // (RULE2) images move only on mapped words
  image_hold_a: assert property ( // (RULE2)
    !ld0 && !ld1 |=> $stable(lnk_cap_o) && $stable(dev_cap_o) && $stable(cap_dis_o)
      && $stable(sw_ctl_o) && $stable(order_o) && $stable(vc_cnt_o))
    else $error("image changed outside its word");
  // (RULE3) status set after last word
  done_last_a: assert property (ld1 |=> load_done_o && sig_ok_o) // (RULE3)
    else $error("status not set after last word");
  // (RULE5) extended VC mapping
  vc_map_a: assert property (ld0 |=> vc_cnt_o[0][0] == $past(w[0]) && vc_cnt_o[2][0] == $past(w[0])) // (RULE5)
    else $error("extended VC count not loaded");
  // (RULE6) L0s latency mapping
  l0s_map_a: assert property (ld0 |=> lnk_cap_o[2][14:12] == $past(w[3:1])) // (RULE6)
    else $error("L0s latency not loaded");
  // (RULE7) L1 latency mapping
  l1_map_a: assert property (ld0 |=> lnk_cap_o[1][17:15] == $past(w[6:4])) // (RULE7)
    else $error("L1 latency not loaded");
  // (RULE8) clock PM mapping
  clkpm_map_a: assert property (ld0 |=> lnk_cap_o[0][18] == $past(w[7])) // (RULE8)
    else $error("clock PM bit not loaded");
  // (RULE9) egress no-ordering mapping
  egr_map_a: assert property (ld0 |=> sw_ctl_o[0][5] == $past(w[8])) // (RULE9)
    else $error("egress ordering bit not loaded");
  // (RULE10) tag no-ordering mapping
  tag_map_a: assert property (ld0 |=> sw_ctl_o[0][6] == $past(w[9])) // (RULE10)
    else $error("tag ordering bit not loaded");
  // (RULE11) store-and-forward mapping
  saf_map_a: assert property (ld0 |=> sw_ctl_o[0][0] == $past(w[10])) // (RULE11)
    else $error("store and forward bit not loaded");
  // (RULE12) threshold mapping
  ct_map_a: assert property (ld0 |=> sw_ctl_o[0][2:1] == $past(w[12:11]) && sw_ctl_o[1][7:0] == 8'h00) // (RULE12)
    else $error("threshold not loaded on port 0 only");
  // (RULE13) arbiter mode mapping
  arb_map_a: assert property (ld0 |=> sw_ctl_o[0][3] == $past(w[13])) // (RULE13)
    else $error("arbiter mode bit not loaded");
  // (RULE14) credit mode mapping
  cred_map_a: assert property (ld0 |=> sw_ctl_o[0][4] == $past(w[14])) // (RULE14)
    else $error("credit mode bit not loaded");
  // (RULE15) non-posted store mapping
  npsaf_map_a: assert property (ld0 |=> sw_ctl_o[0][7] == $past(w[15]) && sw_ctl_o[2][7:0] == 8'h00) // (RULE15)
    else $error("non-posted store bit misplaced");
  // (RULE16) payload mapping
  mps_map_a: assert property ( // (RULE16)
    ld1 |=> dev_cap_o[1][1:0] == $past(w[1:0]) && dev_cap_o[2][15] == $past(w[4]))
    else $error("device capability not loaded");
  // (RULE17) ASPM support mapping
  aspm_map_a: assert property (ld1 |=> lnk_cap_o[0][11:10] == $past(w[3:2])) // (RULE17)
    else $error("ASPM support not loaded");
  // (RULE18) error reporting mapping
  rber_map_a: assert property (ld1 |=> dev_cap_o[0][15] == $past(w[4])) // (RULE18)
    else $error("error reporting bit not loaded");
  // (RULE19) MSI disable mapping
  msi_map_a: assert property (ld1 |=> cap_dis_o[1][14] == $past(w[5])) // (RULE19)
    else $error("MSI disable bit not loaded");
  // (RULE20) compliance parity mapping
  cmp_map_a: assert property (ld1 |=> sw_ctl_o[2][15] == $past(w[6])) // (RULE20)
    else $error("compliance parity bit not loaded");
  // (RULE21) PM disable mapping
  pmdis_map_a: assert property (ld1 |=> cap_dis_o[0][13] == $past(w[7])) // (RULE21)
    else $error("PM disable bit not loaded");
  // (RULE22) ordering rule mapping
  ord_map_a: assert property (ld1 |=> order_o[1][5] == $past(w[8])) // (RULE22)
    else $error("ordering rule bit not loaded");
  // (RULE23) LBN kept off port 0
  lbn_map_a: assert property (ld1 |=> !lnk_cap_o[0][21] && lnk_cap_o[2][21] == $past(w[9])) // (RULE23)
    else $error("link bandwidth bit misplaced");
  // (RULE24) vendor word copied
  vid_map_a: assert property (ldv |=> vendor_id_o == $past(w)) // (RULE24)
    else $error("vendor id not copied");
  // (RULE24) device word copied
  did_map_a: assert property (ldd |=> device_id_o == $past(w)) // (RULE24)
    else $error("device id not copied");
  // (RULE24) subsystem vendor copied
  ssvid_map_a: assert property (lds |=> ss_vendor_o == $past(w)) // (RULE24)
    else $error("subsystem vendor id not copied");
  // (RULE24) subsystem word copied
  ssid_map_a: assert property (ldi |=> ss_id_o == $past(w)) // (RULE24)
    else $error("subsystem id not copied");
  // (RULE3) status never falls outside reset
  done_stick_a: assert property (load_done_o |=> load_done_o) // (RULE3)
    else $error("autoload status dropped");
endmodule : ecal_top
`default_nettype wire

// File: ecal_ee_model.sv
`timescale 1ns/1ns
`default_nettype none
module ecal_ee_model (
  input  wire logic             sys_clk_i,  // Core clock
  input  wire logic             rst_i,      // Sync reset, high
  input  wire logic             req_i,      // Word request, level
  input  wire logic [7:0]       addr_i,     // Byte offset of word
  input  wire logic [6:0][15:0] words_i,    // Image, offsets 00h-0Ch
  input  wire logic [3:0]       lat_i,      // Wait cycles before answer
  output logic                  ack_o,      // Data valid pulse
  output logic [15:0]           rdata_o     // Read word
);
  logic [3:0] cnt;
  // Data toggles outside the ack cycle so stale words never look valid
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ack_o   <= 1'h0;
      cnt     <= 4'h0;
      rdata_o <= 16'hFFFF;
    end else if (req_i && !ack_o && cnt >= lat_i) begin
      ack_o   <= 1'h1;
      cnt     <= 4'h0;
      rdata_o <= (addr_i < 8'h0E) ? words_i[addr_i[3:1]] : ~rdata_o;
    end else begin
      ack_o   <= 1'h0;
      cnt     <= (req_i && !ack_o) ? cnt + 4'h1 : 4'h0;
      rdata_o <= ~rdata_o;
    end
  end
endmodule : ecal_ee_model
`default_nettype wire

// File: eeprom_config_autoload_map_tb.sv
`timescale 1ns/1ns
`default_nettype none
module eeprom_config_autoload_map_tb;
  import ecal_pkg::*;
  logic                       sys_clk_i;
  logic                       rst_i;
  logic                       ee_req_o;
  logic [7:0]                 ee_addr_o;
  logic                       ee_ack_i;
  logic [15:0]                ee_rdata_i;
  logic                       load_done_o;
  logic                       sig_ok_o;
  logic [15:0]                vendor_id_o;
  logic [15:0]                device_id_o;
  logic [15:0]                ss_vendor_o;
  logic [15:0]                ss_id_o;
  logic [NPORT-1:0][31:0]     lnk_cap_o;
  logic [NPORT-1:0][15:0]     dev_cap_o;
  logic [NPORT-1:0][15:0]     cap_dis_o;
  logic [NPORT-1:0][15:0]     sw_ctl_o;
  logic [NPORT-1:0][7:0]      order_o;
  logic [NPORT-1:0][7:0]      vc_cnt_o;
  logic [6:0][15:0]           words;
  logic [3:0]                 lat;
  logic [7:0]                 seen [0:15];
  int                         nacc;
  int                         err_count;
  int                         cmp_count;

  ecal_top uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ee_req_o(ee_req_o), .ee_addr_o(ee_addr_o),
    .ee_ack_i(ee_ack_i), .ee_rdata_i(ee_rdata_i), .load_done_o(load_done_o), .sig_ok_o(sig_ok_o),
    .vendor_id_o(vendor_id_o), .device_id_o(device_id_o), .ss_vendor_o(ss_vendor_o), .ss_id_o(ss_id_o),
    .lnk_cap_o(lnk_cap_o), .dev_cap_o(dev_cap_o), .cap_dis_o(cap_dis_o), .sw_ctl_o(sw_ctl_o),
    .order_o(order_o), .vc_cnt_o(vc_cnt_o));
  ecal_ee_model ee (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(ee_req_o), .addr_i(ee_addr_o),
    .words_i(words), .lat_i(lat), .ack_o(ee_ack_i), .rdata_o(ee_rdata_i));

  initial begin
    sys_clk_i = 1'h0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  // Log of offsets actually taken
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      nacc <= 0;
    end else if (ee_req_o && ee_ack_i) begin
      seen[nacc[3:0]] <= ee_addr_o;
      nacc            <= nacc + 1;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic final_report;
    $display("Checks %0d, errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  // Reset, then let the model serve the image
  task automatic start_load(input logic [15:0] sig, input logic [15:0] m0, input logic [15:0] m1,
                            input logic [3:0] l);
    @(posedge sys_clk_i);
    rst_i <= 1'h1;
    words <= {m1, 16'h5AA5 ^ m0, 16'hC33C ^ m1, m0, 16'h1234 ^ m1, 16'h8421 ^ m0, sig};
    lat   <= l;
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'h0;
  endtask : start_load

  task automatic wait_done;
    int i;
    for (i = 0; i < 400 && load_done_o !== 1'h1; i++) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask : wait_done

  task automatic check_all(input logic ok, input logic [15:0] m0, input logic [15:0] m1);
    logic [15:0] a;
    logic [15:0] b;
    logic [31:0] el;
    logic [15:0] es;
    int          p;
    int          n;
    a = ok ? m0 : 16'h0000;
    b = ok ? m1 : 16'h0000;
    n = ok ? 7 : 1;
    chk("load_done", 32'h1, {31'h0, load_done_o});
    chk("sig_ok", {31'h0, ok}, {31'h0, sig_ok_o});
    chk("words taken", n, nacc);
    for (p = 0; p < n; p++) chk("offset", 2 * p, {24'h0, seen[p]});
    chk("vendor", ok ? 16'h8421 ^ a : 32'h0, {16'h0, vendor_id_o});
    chk("device", ok ? 16'h1234 ^ b : 32'h0, {16'h0, device_id_o});
    chk("ss_vendor", ok ? 16'hC33C ^ b : 32'h0, {16'h0, ss_vendor_o});
    chk("ss_id", ok ? 16'h5AA5 ^ a : 32'h0, {16'h0, ss_id_o});
    for (p = 0; p < NPORT; p++) begin
      el = {10'h0, b[9] && p != 0, 2'h0, a[7:1], b[3:2], 10'h0};
      es = {b[6], 7'h0, (p == 0) ? {a[15], a[9], a[8], a[14], a[13], a[12:11], a[10]} : 8'h00};
      chk("lnk_cap", el, lnk_cap_o[p]);
      chk("dev_cap", {16'h0, b[4], 13'h0, b[1:0]}, {16'h0, dev_cap_o[p]});
      chk("cap_dis", {17'h0, b[5], b[7], 13'h0}, {16'h0, cap_dis_o[p]});
      chk("sw_ctl", {16'h0, es}, {16'h0, sw_ctl_o[p]});
      chk("order", {26'h0, b[8], 5'h0}, {24'h0, order_o[p]});
      chk("vc_cnt", {31'h0, a[0]}, {24'h0, vc_cnt_o[p]});
    end
  endtask : check_all

  task automatic t_good_fast;
    start_load(16'h1516, 16'hA5C3, 16'h02B5, 4'h0);
    wait_done();
    check_all(1'h1, 16'hA5C3, 16'h02B5);
  endtask : t_good_fast

  task automatic t_good_slow;
    start_load(16'h1516, 16'h5A3C, 16'h034A, 4'h6);
    wait_done();
    check_all(1'h1, 16'h5A3C, 16'h034A);
  endtask : t_good_slow

  task automatic t_bad_sig;
    start_load(16'h1517, 16'hFFFF, 16'hFFFF, 4'h2);
    wait_done();
    repeat (20) @(negedge sys_clk_i);
    check_all(1'h0, 16'hFFFF, 16'hFFFF);
  endtask : t_bad_sig

  task automatic t_reset_mid;
    int i;
    start_load(16'h1516, 16'hFFFF, 16'h03FF, 4'h1);
    for (i = 0; i < 200 && nacc < 4; i++) @(posedge sys_clk_i);
    rst_i <= 1'h1;
    repeat (2) @(negedge sys_clk_i);
    chk("req in reset", 32'h0, {31'h0, ee_req_o});
    chk("done in reset", 32'h0, {31'h0, load_done_o});
    chk("vc in reset", 32'h0, {24'h0, vc_cnt_o[0]});
    start_load(16'h1516, 16'h8001, 16'h0201, 4'h3);
    wait_done();
    check_all(1'h1, 16'h8001, 16'h0201);
  endtask : t_reset_mid

  initial begin
    err_count = 0;
    cmp_count = 0;
    rst_i     = 1'h1;
    lat       = 4'h0;
    words     = '0;
    t_good_fast();
    t_good_slow();
    t_bad_sig();
    t_reset_mid();
    final_report();
  end

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    err_count++;
    final_report();
  end
endmodule : eeprom_config_autoload_map_tb
`default_nettype wire
